//--- logic/smb_dev.sv
// Overview of operation
// - Master opens each transfer with start
// - Shift in 7-bit address, then direction
// - Matching address acknowledged on ninth clock
// - Nine clocks per byte; SDA rise = stop
// - First written byte is the command
// - Master sets read address by write first
// - Master ends write with stop
// - Master ends read with NACK then stop
// - Long SCL low times out transaction
// - Clock flush makes device release SDA
// - RAM 0x00-0xDF, EEPROM 0xF800-0xFBFF decoded
// - EEPROM writes only erased bytes; page erase
// - Erase needs enable bit 2 at 0x90
// - Send byte: address, command, stop
// - Send byte with RAM address loads pointer
// - Command 0xFE erases previously addressed page
// - Erase starts when command byte accepted
// - Erase busy about 20 ms, NACK meanwhile
// - Address is 01111 plus two pins
// - NACK everything until 1 ms load done
// - Write word 0xF8-0xFB sets EEPROM pointer
// - Erase uses only upper three low-byte bits
//
// Local design decision: register access over AXI4-Lite.
module smb_dev #(
  parameter int TIMEOUT_CYC = smb_pkg::TIMEOUT_CYC,
  parameter int ERASE_CYC = smb_pkg::ERASE_CYC,
  parameter int BOOT_CYC = smb_pkg::BOOT_CYC
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Address select pins
  input wire logic I_ADDR_SELECT_HI_PIN,
  input wire logic I_ADDR_SELECT_LO_PIN,
  // Status
  output logic O_READY,
  output logic O_BUSY,
  // Bus
  smb_if.device bus
);
  typedef enum logic [2:0] {D_IDLE, D_RX, D_ACK, D_TX, D_MACK} smb_dst_t;
  typedef struct packed {
    smb_dst_t st;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic rw;
    logic [1:0] nb;
    logic [7:0] cmd;
    logic [15:0] ptr;
    logic sda_oe;
    logic scl_p;
    logic sda_p;
    smb_pkg::smb_cnt_t tmo;
    smb_pkg::smb_cnt_t wait_cnt;
    logic ready;
    logic busy;
    logic erasing;
    logic [4:0] eidx;
    logic [7:0] ucfg;
    logic [6:0] own;
  } smb_dstate_t;

  smb_dstate_t q;
  smb_dstate_t next_q;
  logic [3:0] sy;
  logic scl;
  logic sda;
  logic rise;
  logic fall;
  logic [7:0] rd;
  logic [7:0] ee_old;
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;
  logic ee_we;
  logic [9:0] ee_wa;
  logic [7:0] ee_wd;
  logic [7:0] ram [0:smb_pkg::RAM_BYTES-1];
  logic [7:0] ee [0:smb_pkg::EE_BYTES-1];

  // ==========================================================
  // Pin synchronisers
  smb_sync #(.W(4), .INIT(4'hF)) u_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_d({bus.scl, bus.sda, I_ADDR_SELECT_HI_PIN, I_ADDR_SELECT_LO_PIN}),
    .o_q(sy)
  );

  assign scl = sy[3];
  assign sda = sy[2];
  assign rise = scl & ~q.scl_p;
  assign fall = ~scl & q.scl_p;
  assign ee_old = ee[q.ptr[9:0]];

  // ==========================================================
  // Read data decode
  always_comb begin
    rd = smb_pkg::ERASED;
    if (q.ptr[15:8] == 8'h00 && q.ptr[7:0] <= smb_pkg::RAM_LAST) begin
      rd = (q.ptr[7:0] == smb_pkg::UCFG_OFS) ? q.ucfg : ram[q.ptr[7:0]];
    end else if (q.ptr[15:8] >= smb_pkg::EE_HI_FIRST && q.ptr[15:8] <= smb_pkg::EE_HI_LAST) begin
      rd = ee_old;
    end
  end

  // ==========================================================
  // Protocol engine
  always_comb begin
    next_q = q;
    ram_we = 1'b0;
    ram_wa = q.cmd;
    ram_wd = q.sh;
    ee_we = 1'b0;
    ee_wa = q.ptr[9:0];
    ee_wd = q.sh;
    next_q.scl_p = scl;
    next_q.sda_p = sda;
    next_q.own = {smb_pkg::ADDR_FIXED, sy[1], sy[0]};

    // Shared counter: configuration load, then erase time
    if (!q.ready) begin
      next_q.wait_cnt = q.wait_cnt + 20'h00001;
      if (q.wait_cnt == smb_pkg::smb_cnt_t'(BOOT_CYC - 1)) begin
        next_q.ready = 1'b1;
        next_q.wait_cnt = '0;
      end
    end else if (q.busy) begin
      next_q.wait_cnt = q.wait_cnt + 20'h00001;
      if (q.wait_cnt == smb_pkg::smb_cnt_t'(ERASE_CYC - 1)) begin
        next_q.busy = 1'b0;
      end
    end

    // Page wipe, one byte per cycle; low five pointer bits ignored
    if (q.erasing) begin
      ee_we = 1'b1;
      ee_wa = {q.ptr[9:5], q.eidx};
      ee_wd = smb_pkg::ERASED;
      next_q.eidx = q.eidx + 5'h01;
      if (q.eidx == 5'h1F) begin
        next_q.erasing = 1'b0;
      end
    end

    if (scl || q.st == D_IDLE) begin
      next_q.tmo = '0;
    end else begin
      next_q.tmo = q.tmo + 20'h00001;
    end

    if (scl && q.scl_p && q.sda_p && !sda) begin
      // Start: only taken once loaded and not erasing
      next_q.sda_oe = 1'b0;
      next_q.bitc = 4'h0;
      next_q.nb = 2'h0;
      next_q.st = (q.ready && !q.busy) ? D_RX : D_IDLE;
    end else if (scl && q.scl_p && !q.sda_p && sda) begin
      next_q.st = D_IDLE;
      next_q.sda_oe = 1'b0;
    end else if (q.st != D_IDLE && q.tmo == smb_pkg::smb_cnt_t'(TIMEOUT_CYC - 1)) begin
      next_q.st = D_IDLE;
      next_q.sda_oe = 1'b0;
    end else begin
      case (q.st)
        D_RX: begin
          if (rise) begin
            next_q.sh = {q.sh[6:0], sda};
            next_q.bitc = q.bitc + 4'h1;
          end else if (fall && q.bitc == 4'h8) begin
            next_q.st = D_ACK;
            next_q.sda_oe = 1'b1;
            next_q.nb = (q.nb == 2'h3) ? 2'h3 : q.nb + 2'h1;
            case (q.nb)
              2'h0: begin
                if (q.sh[7:1] != q.own) begin
                  next_q.st = D_IDLE;
                  next_q.sda_oe = 1'b0;
                end else begin
                  next_q.rw = q.sh[0];
                end
              end
              2'h1: begin
                next_q.cmd = q.sh;
                if (q.sh <= smb_pkg::RAM_LAST) begin
                  next_q.ptr = {8'h00, q.sh};
                end
                // Busy at once, so the stop may follow directly
                if (q.sh == smb_pkg::CMD_ERASE && q.ucfg[smb_pkg::UCFG_ERASE_EN_BIT]) begin
                  next_q.erasing = 1'b1;
                  next_q.busy = 1'b1;
                  next_q.eidx = 5'h00;
                  next_q.wait_cnt = '0;
                end
              end
              2'h2: begin
                if (q.cmd <= smb_pkg::RAM_LAST) begin
                  ram_we = 1'b1;
                  if (q.cmd == smb_pkg::UCFG_OFS) begin
                    next_q.ucfg = q.sh;
                  end
                end else if (q.cmd >= smb_pkg::EE_HI_FIRST && q.cmd <= smb_pkg::EE_HI_LAST) begin
                  next_q.ptr = {q.cmd, q.sh};
                end
              end
              default: begin
                // Programmed bytes refuse new data until erased
                if (q.cmd >= smb_pkg::EE_HI_FIRST && q.cmd <= smb_pkg::EE_HI_LAST
                    && ee_old == smb_pkg::ERASED) begin
                  ee_we = 1'b1;
                end
              end
            endcase
          end
        end
        D_ACK: begin
          if (fall) begin
            next_q.bitc = 4'h0;
            if (q.rw) begin
              next_q.st = D_TX;
              next_q.sh = rd;
              next_q.sda_oe = ~rd[7];
            end else begin
              next_q.st = D_RX;
              next_q.sda_oe = 1'b0;
            end
          end
        end
        D_TX: begin
          if (rise) begin
            next_q.bitc = q.bitc + 4'h1;
          end else if (fall) begin
            if (q.bitc == 4'h8) begin
              next_q.sda_oe = 1'b0;
              next_q.st = D_MACK;
            end else begin
              next_q.sh = {q.sh[6:0], 1'b0};
              next_q.sda_oe = ~q.sh[6];
            end
          end
        end
        D_MACK: begin
          if (rise) begin
            next_q.st = sda ? D_IDLE : D_ACK;
          end
        end
        default: begin
          next_q.st = D_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      q <= '{st: D_IDLE, bitc: 4'h0, sh: 8'h00, rw: 1'b0, nb: 2'h0, cmd: 8'h00, ptr: 16'h0000,
             sda_oe: 1'b0, scl_p: 1'b1, sda_p: 1'b1, tmo: '0, wait_cnt: '0, ready: 1'b0,
             busy: 1'b0, erasing: 1'b0, eidx: 5'h00, ucfg: smb_pkg::UCFG_RESET, own: 7'h00};
    end else begin
      q <= next_q;
    end
  end

  // Memories carry no reset; contents are unknown until written
  always_ff @(posedge I_CLK) begin
    if (ram_we) begin
      ram[ram_wa] <= ram_wd;
    end
    if (ee_we) begin
      ee[ee_wa] <= ee_wd;
    end
  end

  assign bus.dev_sda_oe = q.sda_oe;
  assign bus.dev_sda_o = 1'b0;
  assign O_READY = q.ready;
  assign O_BUSY = q.busy;
endmodule // smb_dev

//--- logic/smb_host.sv
module smb_host (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // AXI4-Lite write
  input wire logic I_AWVALID,
  input wire logic [7:0] I_AWADDR,
  output logic O_AWREADY,
  input wire logic I_WVALID,
  input wire logic [31:0] I_WDATA,
  input wire logic [3:0] I_WSTRB,
  output logic O_WREADY,
  output logic O_BVALID,
  output logic [1:0] O_BRESP,
  input wire logic I_BREADY,
  // AXI4-Lite read
  input wire logic I_ARVALID,
  input wire logic [7:0] I_ARADDR,
  output logic O_ARREADY,
  output logic O_RVALID,
  output logic [31:0] O_RDATA,
  output logic [1:0] O_RRESP,
  input wire logic I_RREADY,
  // Bus
  smb_if.host bus
);
  typedef enum logic [2:0] {H_IDLE, H_START, H_BIT, H_STOP, H_FLUSH} smb_hst_t;
  typedef struct packed {
    smb_hst_t st;
    logic [7:0] qc;
    logic [1:0] ph;
    logic [3:0] bitc;
    logic [1:0] nb;
    logic [4:0] fc;
    logic [7:0] sh;
    logic scl_oe;
    logic sda_oe;
    logic busy;
    logic nack;
    logic [7:0] rdat;
    logic [9:0] ctrl;
    logic [23:0] wdat;
    logic aw_got;
    logic w_got;
    logic [7:0] awaddr;
    logic [31:0] wd;
    logic [3:0] ws;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } smb_hstate_t;

  smb_hstate_t q;
  smb_hstate_t next_q;
  logic sy;
  logic sda;
  logic tick;
  logic rxb;
  logic [31:0] m;

  // Only data is read back; this end alone drives the clock line
  smb_sync #(.W(1), .INIT(1'h1)) u_sync (
    .i_clk(I_CLK),
    .i_srst(I_SRST),
    .i_d(bus.sda),
    .o_q(sy)
  );

  assign sda = sy;
  assign tick = (q.qc == 8'(smb_pkg::QTR_CYC - 1));
  assign rxb = q.ctrl[7] && q.nb != 2'h0;
  assign m = {{8{q.ws[3]}}, {8{q.ws[2]}}, {8{q.ws[1]}}, {8{q.ws[0]}}};

  always_comb begin
    next_q = q;
    // ==========================================================
    // Register slave
    if (q.bvalid && I_BREADY) begin
      next_q.bvalid = 1'b0;
    end
    if (I_AWVALID && q.awready) begin
      next_q.aw_got = 1'b1;
      next_q.awaddr = I_AWADDR;
    end
    if (I_WVALID && q.wready) begin
      next_q.w_got = 1'b1;
      next_q.wd = I_WDATA;
      next_q.ws = I_WSTRB;
    end
    if (q.aw_got && q.w_got && !q.bvalid) begin
      next_q.aw_got = 1'b0;
      next_q.w_got = 1'b0;
      next_q.bvalid = 1'b1;
      next_q.bresp = smb_pkg::RESP_OKAY;
      case (q.awaddr)
        smb_pkg::REG_CTRL: begin
          next_q.ctrl = (q.ctrl & ~m[9:0]) | (q.wd[9:0] & m[9:0]);
          // Orders while a transfer runs are dropped
          if (!q.busy && q.ws[2] && q.wd[smb_pkg::CTRL_FLUSH_BIT]) begin
            next_q.st = H_FLUSH;
            next_q.busy = 1'b1;
            next_q.fc = 5'h00;
          end else if (!q.busy && q.ws[2] && q.wd[smb_pkg::CTRL_GO_BIT]) begin
            next_q.st = H_START;
            next_q.busy = 1'b1;
            next_q.nack = 1'b0;
          end
        end
        smb_pkg::REG_DATA: begin
          next_q.wdat = (q.wdat & ~m[23:0]) | (q.wd[23:0] & m[23:0]);
        end
        default: begin
          next_q.bresp = smb_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_q.awready = ~next_q.aw_got & ~next_q.bvalid;
    next_q.wready = ~next_q.w_got & ~next_q.bvalid;

    if (q.rvalid && I_RREADY) begin
      next_q.rvalid = 1'b0;
    end
    if (I_ARVALID && q.arready) begin
      next_q.rvalid = 1'b1;
      next_q.rresp = smb_pkg::RESP_OKAY;
      case (I_ARADDR)
        smb_pkg::REG_CTRL: next_q.rdata = {22'h000000, q.ctrl};
        smb_pkg::REG_DATA: next_q.rdata = {8'h00, q.wdat};
        smb_pkg::REG_STATUS: next_q.rdata = {16'h0000, q.rdat, 6'h00, q.nack, q.busy};
        default: begin
          next_q.rdata = 32'h00000000;
          next_q.rresp = smb_pkg::RESP_SLVERR;
        end
      endcase
    end
    next_q.arready = ~next_q.rvalid;

    // ==========================================================
    // Bus engine, four quarters per SCL period
    if (q.st == H_IDLE) begin
      next_q.qc = 8'h00;
      next_q.ph = 2'h0;
    end else begin
      next_q.qc = tick ? 8'h00 : q.qc + 8'h01;
      if (tick) begin
        next_q.ph = q.ph + 2'h1;
        case (q.st)
          H_START: begin
            if (q.ph == 2'h1) begin
              next_q.sda_oe = 1'b1;
            end else if (q.ph == 2'h3) begin
              next_q.scl_oe = 1'b1;
              next_q.st = H_BIT;
              next_q.bitc = 4'h0;
              next_q.nb = 2'h0;
              // Address byte is the 7-bit address, then direction last
              next_q.sh = {q.ctrl[6:0], q.ctrl[7]};
            end
          end
          H_BIT: begin
            case (q.ph)
              2'h0: next_q.sda_oe = (q.bitc == 4'h8 || rxb) ? 1'b0 : ~q.sh[7];
              2'h1: next_q.scl_oe = 1'b0;
              2'h2: begin
                if (q.bitc != 4'h8) begin
                  next_q.sh = {q.sh[6:0], sda};
                end else if (!rxb) begin
                  next_q.nack = sda;
                end
              end
              default: begin
                next_q.scl_oe = 1'b1;
                next_q.bitc = q.bitc + 4'h1;
                if (q.bitc == 4'h8) begin
                  next_q.bitc = 4'h0;
                  if (rxb) begin
                    next_q.rdat = q.sh;
                    next_q.st = H_STOP;
                  end else if (q.nack) begin
                    next_q.st = H_STOP;
                  end else if (q.ctrl[7]) begin
                    next_q.nb = 2'h1;
                  end else if (q.nb == q.ctrl[9:8]) begin
                    next_q.st = H_STOP;
                  end else begin
                    next_q.nb = q.nb + 2'h1;
                    next_q.sh = q.wdat[{q.nb, 3'h0} +: 8];
                  end
                end
              end
            endcase
          end
          H_FLUSH: begin
            if (q.ph == 2'h1) begin
              next_q.scl_oe = 1'b0;
            end else if (q.ph == 2'h3) begin
              next_q.scl_oe = 1'b1;
              next_q.fc = q.fc + 5'h01;
              if (q.fc == 5'(smb_pkg::FLUSH_PULSES - 1)) begin
                next_q.st = H_STOP;
              end
            end
          end
          H_STOP: begin
            case (q.ph)
              2'h0: next_q.sda_oe = 1'b1;
              2'h1: next_q.scl_oe = 1'b0;
              2'h2: next_q.sda_oe = 1'b0;
              default: begin
                next_q.busy = 1'b0;
                next_q.st = H_IDLE;
              end
            endcase
          end
          default: next_q.st = H_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      q <= '0;
    end else begin
      q <= next_q;
    end
  end

  assign O_AWREADY = q.awready;
  assign O_WREADY = q.wready;
  assign O_BVALID = q.bvalid;
  assign O_BRESP = q.bresp;
  assign O_ARREADY = q.arready;
  assign O_RVALID = q.rvalid;
  assign O_RDATA = q.rdata;
  assign O_RRESP = q.rresp;
  assign bus.host_scl_oe = q.scl_oe;
  assign bus.host_sda_oe = q.sda_oe;
  assign bus.host_scl_o = 1'b0;
  assign bus.host_sda_o = 1'b0;
endmodule // smb_host

//--- logic/smb_if.sv
interface smb_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  // Open-drain wires with pull-ups
  assign scl = ~host_scl_oe;
  assign sda = ~(host_sda_oe | dev_sda_oe);

  modport device (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe, output host_sda_o, output host_sda_oe);
endinterface

//--- logic/smb_pkg.sv
package smb_pkg;
  // ==========================================================
  // Clock and timing
  localparam int CLK_NS = 50;
  localparam int TIMEOUT_MS = 30;
  localparam int ERASE_MS = 20;
  localparam int BOOT_MS = 1;
  localparam int TIMEOUT_CYC = TIMEOUT_MS * 1000000 / CLK_NS;
  localparam int ERASE_CYC = ERASE_MS * 1000000 / CLK_NS;
  localparam int BOOT_CYC = BOOT_MS * 1000000 / CLK_NS;
  localparam int SCL_PERIOD_NS = 10000;
  localparam int QTR_CYC = SCL_PERIOD_NS / (4 * CLK_NS);
  localparam int FLUSH_PULSES = 16;
  typedef logic [19:0] smb_cnt_t;

  // ==========================================================
  // Device address map and commands
  localparam logic [4:0] ADDR_FIXED = 5'h0F;
  localparam logic [7:0] RAM_LAST = 8'hDF;
  localparam logic [7:0] EE_HI_FIRST = 8'hF8;
  localparam logic [7:0] EE_HI_LAST = 8'hFB;
  localparam logic [7:0] CMD_ERASE = 8'hFE;
  localparam logic [7:0] UCFG_OFS = 8'h90;
  localparam logic [7:0] UCFG_RESET = 8'h00;
  localparam int UCFG_ERASE_EN_BIT = 2;
  localparam logic [7:0] ERASED = 8'hFF;
  localparam int RAM_BYTES = 224;
  localparam int EE_BYTES = 1024;

  // ==========================================================
  // Host controller registers
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam int CTRL_GO_BIT = 16;
  localparam int CTRL_FLUSH_BIT = 17;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

//--- logic/smb_sync.sv
module smb_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // Data
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);
  logic [W-1:0] meta;

  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      meta <= INIT;
      o_q <= INIT;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end
endmodule // smb_sync

//--- testbench/smb_props.sv
module smb_props #(
  parameter int TIMEOUT_CYC = 2000,
  parameter int ERASE_CYC = 6000,
  parameter int BOOT_CYC = 3000
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_SRST,
  // Watched lines
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  input wire logic O_READY,
  input wire logic O_BUSY
);
  // ==========================================================
  // Helper counters
  logic [19:0] low_cnt;
  logic [19:0] busy_cnt;
  logic [19:0] up_cnt;
  always_ff @(posedge I_CLK) begin
    if (I_SRST) begin
      low_cnt <= '0;
      busy_cnt <= '0;
      up_cnt <= '0;
    end else begin
      low_cnt <= scl ? '0 : low_cnt + 20'h1;
      busy_cnt <= O_BUSY ? busy_cnt + 20'h1 : '0;
      up_cnt <= O_READY ? up_cnt : up_cnt + 20'h1;
    end
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_SRST);
  a_oe_moves_low: assert property ($changed(dev_sda_oe) |-> !scl)
    else $error("device data moved while clock high");
  a_ack_held_high: assert property ($rose(dev_sda_oe) |-> dev_sda_oe throughout (##[1:120] scl ##[1:120] !scl))
    else $error("device low not held through clock high");
  a_boot_quiet: assert property (!O_READY |-> !dev_sda_oe)
    else $error("device drove data before ready");
  a_boot_time: assert property ($rose(O_READY) |-> up_cnt >= BOOT_CYC - 1 && up_cnt <= BOOT_CYC + 1)
    else $error("ready rose at wrong time");
  a_erase_span: assert property ($fell(O_BUSY) |-> busy_cnt >= ERASE_CYC - 1 && busy_cnt <= ERASE_CYC + 1)
    else $error("erase busy length wrong");
  a_busy_nack: assert property (O_BUSY && busy_cnt > 400 |-> !dev_sda_oe)
    else $error("device answered while erasing");
  a_timeout_free: assert property (low_cnt > TIMEOUT_CYC + 8 |-> !dev_sda_oe)
    else $error("data still held after clock low timeout");
  a_start_form: assert property ($fell(sda) && scl |-> $past(scl))
    else $error("data fell together with clock rise");
endmodule // smb_props

//--- testbench/test_smbus_slave_mem_access.sv
module test_smbus_slave_mem_access;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TO_C = 2000;
  localparam int ER_C = 3500;
  localparam int BT_C = 3000;
  localparam logic [6:0] DEV = {smb_pkg::ADDR_FIXED, 2'b10};
  localparam logic [1:0] OK = smb_pkg::RESP_OKAY;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hF;
  logic pin_hi = 1'b1;
  logic pin_lo = 1'b0;
  logic awr, wr, bv, arr, rv, rdy, bsy;
  logic [1:0] br, rr;
  logic [31:0] rd;
  int bad_count = 0;
  int checked = 0;
  smb_if smb_if_i ();
  smb_dev #(.TIMEOUT_CYC(TO_C), .ERASE_CYC(ER_C), .BOOT_CYC(BT_C)) smb_dev_i (.I_CLK(clk), .I_SRST(srst),
    .I_ADDR_SELECT_HI_PIN(pin_hi), .I_ADDR_SELECT_LO_PIN(pin_lo), .O_READY(rdy), .O_BUSY(bsy), .bus(smb_if_i));
  smb_host smb_host_i (.I_CLK(clk), .I_SRST(srst), .I_AWVALID(awv), .I_AWADDR(awa), .O_AWREADY(awr),
    .I_WVALID(wv), .I_WDATA(wd), .I_WSTRB(ws), .O_WREADY(wr), .O_BVALID(bv), .O_BRESP(br), .I_BREADY(bry),
    .I_ARVALID(arv), .I_ARADDR(ara), .O_ARREADY(arr), .O_RVALID(rv), .O_RDATA(rd), .O_RRESP(rr),
    .I_RREADY(rry), .bus(smb_if_i));
  smb_props #(.TIMEOUT_CYC(TO_C), .ERASE_CYC(ER_C), .BOOT_CYC(BT_C)) smb_props_i (.I_CLK(clk), .I_SRST(srst),
    .scl(smb_if_i.scl), .sda(smb_if_i.sda), .dev_sda_oe(smb_if_i.dev_sda_oe), .O_READY(rdy), .O_BUSY(bsy));
  initial forever #25 clk = ~clk;
  // ==========================================================
  // Shared tasks
  task automatic check(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic end_of_test();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Ready is sampled mid-cycle; it only moves on the rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
    logic ta, tw, tb, done;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clk);
    awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; bry <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ta = awr; tw = wr; tb = bv; r = br;
      @(posedge clk);
      if (ta) awv <= 1'b0;
      if (tw) wv <= 1'b0;
      if (tb) begin
        bry <= 1'b0;
        done = 1'b1;
      end
    end
    check({30'h0, r}, {30'h0, e});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [1:0] e, output logic [31:0] d);
    logic ta, tb, done;
    logic [1:0] r;
    done = 1'b0;
    @(posedge clk);
    arv <= 1'b1; ara <= a; rry <= 1'b1;
    while (!done) begin
      @(negedge clk);
      ta = arr; tb = rv; d = rd; r = rr;
      @(posedge clk);
      if (ta) arv <= 1'b0;
      if (tb) begin
        rry <= 1'b0;
        done = 1'b1;
      end
    end
    check({30'h0, r}, {30'h0, e});
  endtask
  task automatic wait_idle(output logic [31:0] st);
    st = 32'h1;
    for (int n = 0; n < 200 && st[0] !== 1'b0; n++) begin
      repeat (100) @(posedge clk);
      axi_rd(smb_pkg::REG_STATUS, OK, st);
    end
    check({31'h0, st[0]}, 32'h0);
  endtask
  // Data layout: second data, first data, command
  task automatic xfer(input logic [6:0] ad, input logic dir, input logic [1:0] nb, input logic [23:0] dat,
                      output logic [31:0] st);
    axi_wr(smb_pkg::REG_DATA, {8'h00, dat}, OK);
    axi_wr(smb_pkg::REG_CTRL, (32'h1 << smb_pkg::CTRL_GO_BIT) | {22'h0, nb, dir, ad}, OK);
    wait_idle(st);
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_boot();
    logic [31:0] st;
    check({31'h0, rdy}, 32'h0);
    xfer(DEV, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h1);
    for (int n = 0; n < 5000 && rdy !== 1'b1; n++) @(posedge clk);
    check({31'h0, rdy}, 32'h1);
  endtask
  task automatic t_addr();
    logic [31:0] st;
    xfer(DEV ^ 7'h01, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h1);
    // Both select pins moved: the new address must answer
    pin_hi <= 1'b0;
    pin_lo <= 1'b1;
    xfer(DEV ^ 7'h03, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h0);
    pin_hi <= 1'b1;
    pin_lo <= 1'b0;
    xfer(DEV, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h0);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    axi_wr(8'h0C, 32'h0, smb_pkg::RESP_SLVERR);
    axi_rd(8'h0C, smb_pkg::RESP_SLVERR, d);
    check(d, 32'h0);
  endtask
  task automatic t_ram();
    logic [31:0] st;
    xfer(DEV, 1'b0, 2'd2, {8'h00, 8'h5C, smb_pkg::RAM_LAST}, st);
    check({31'h0, st[1]}, 32'h0);
    xfer(DEV, 1'b0, 2'd1, {16'h0, smb_pkg::RAM_LAST}, st);
    check({31'h0, st[1]}, 32'h0);
    xfer(DEV, 1'b1, 2'd0, 24'h0, st);
    check({24'h0, st[15:8]}, 32'h5C);
  endtask
  task automatic t_erase();
    logic [31:0] st;
    xfer(DEV, 1'b0, 2'd2, {8'h00, 8'h3F, smb_pkg::EE_HI_FIRST}, st);
    xfer(DEV, 1'b0, 2'd1, {16'h0, smb_pkg::CMD_ERASE}, st);
    check({31'h0, bsy}, 32'h0);
    xfer(DEV, 1'b0, 2'd2, {8'h00, 8'(1 << smb_pkg::UCFG_ERASE_EN_BIT), smb_pkg::UCFG_OFS}, st);
    xfer(DEV, 1'b0, 2'd2, {8'h00, 8'h3F, smb_pkg::EE_HI_FIRST}, st);
    xfer(DEV, 1'b0, 2'd1, {16'h0, smb_pkg::CMD_ERASE}, st);
    check({31'h0, st[1]}, 32'h0);
    check({31'h0, bsy}, 32'h1);
    xfer(DEV, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h1);
    for (int n = 0; n < 10000 && bsy !== 1'b0; n++) @(posedge clk);
    xfer(DEV, 1'b0, 2'd2, {8'h00, 8'h25, smb_pkg::EE_HI_FIRST}, st);
    xfer(DEV, 1'b1, 2'd0, 24'h0, st);
    check({24'h0, st[15:8]}, {24'h0, smb_pkg::ERASED});
    xfer(DEV, 1'b0, 2'd3, {8'h5A, 8'h25, smb_pkg::EE_HI_FIRST}, st);
    xfer(DEV, 1'b1, 2'd0, 24'h0, st);
    check({24'h0, st[15:8]}, 32'h5A);
    // Programmed byte must refuse a second write
    xfer(DEV, 1'b0, 2'd3, {8'h00, 8'h25, smb_pkg::EE_HI_FIRST}, st);
    xfer(DEV, 1'b1, 2'd0, 24'h0, st);
    check({24'h0, st[15:8]}, 32'h5A);
  endtask
  task automatic t_flush();
    logic [31:0] st;
    axi_wr(smb_pkg::REG_CTRL, 32'h1 << smb_pkg::CTRL_FLUSH_BIT, OK);
    wait_idle(st);
    check({31'h0, smb_if_i.dev_sda_oe}, 32'h0);
    xfer(DEV, 1'b0, 2'd0, 24'h0, st);
    check({31'h0, st[1]}, 32'h0);
  endtask
  // ==========================================================
  // Main sequence and watchdog
  initial begin
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    repeat (2) @(posedge clk);
    t_boot();
    t_addr();
    t_regs();
    t_ram();
    t_erase();
    t_flush();
    end_of_test();
  end
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    $display("Error at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule // test_smbus_slave_mem_access
